// *** hdl/usd_defines.vh ***
// Register offsets, field positions, reset values and timing counts of the USB status block
`ifndef USD_DEFINES_VH
`define USD_DEFINES_VH
`define USD_OFF_MAIN_CTRL   16'h1000
`define USD_OFF_IRQ_STATUS  16'h1040
`define USD_OFF_TEST_CTRL   16'h1044
`define USD_OFF_TEST_RESULT 16'h1048
`define USD_OFF_TX_DMA_CTRL 16'h1060
`define USD_OFF_TX_BUF1     16'h1064
`define USD_OFF_TX_BUF2     16'h1068
`define USD_OFF_RX_DMA_CTRL 16'h106c
`define USD_OFF_RX_BUF1     16'h1070
`define USD_OFF_RX_BUF2     16'h1074
`define USD_OFF_RX_SIZE1    16'h1078
`define USD_OFF_RX_SIZE2    16'h107c
`define USD_RESET_VALUE     32'h0000_0000
`define USD_BIT_SOF         0
`define USD_BIT_CONTROL_ENDPOINT_TRANSMIT      1
`define USD_BIT_CONTROL_ENDPOINT_RECEIVE      2
`define USD_BIT_INT_EP      3
`define USD_BIT_BULK_TX     4
`define USD_BIT_BULK_RX     5
`define USD_BIT_TX_BUF_END  6
`define USD_BIT_RX_BUF_END  7
`define USD_BIT_RX_XFER_END 8
`define USD_BIT_SUSPEND     9
`define USD_BIT_WAKEUP      10
`define USD_BIT_BUS_RESET   11
`define USD_ENABLE_BASE     16
`define USD_STATUS_W        12
`define USD_TEST_EN         0
`define USD_TEST_SM_LO      1
`define USD_TEST_SM_HI      3
`define USD_TEST_CNT_LO     4
`define USD_TEST_CNT_HI     5
`define USD_TEST_LOAD_LO    8
`define USD_TEST_LOAD_HI    14
`define USD_TEST_CTRL_MASK  32'h0000_7f3f
`define USD_DMA_ENABLE      0
`define USD_DMA_TWO_BUF     2
`define USD_DMA_OWN1        8
`define USD_DMA_OWN2        9
`define USD_DMA_EOT1        10
`define USD_DMA_EOT2        11
`define USD_DMA_ISO_END     16
`define USD_BUF_SIZE_LO     16
`define USD_BUF_SIZE_HI     27
`define USD_BUF_ADDR_HI     14
`define USD_BUF_END_LO      16
`define USD_BUF_END_HI      30
`define USD_PKT_BYTES       12'd64
`define USD_FRAMES_SUSPEND  3'd5
`define USD_CLK_HZ          100000000
`define USD_IDLE_US         3000
`define USD_WAKE_WAIT_US    5000
`define USD_WAKE_DRIVE_US   11000
`define USD_US_CYCLES(us)   (((us) * (`USD_CLK_HZ / 1000)) / 1000)
`endif

// *** hdl/usd_status.v ***
// USB device interrupt status, test counters, suspend timing and DMA buffer walk
// Contract
// RULE1: SOF edge sets bit 0 if enabled
// RULE2: END_OF_TRANSACTION sets Control_endpoint_transmit/rx or interrupt bits
// RULE3: END_OF_TRANSACTION sets bulk tx/rx bits 4/5
// RULE4: Transmit buffer end sets bit 6
// RULE5: Receive buffer end sets bit 7
// RULE6: Short or empty packet sets bit 8
// RULE7: Five missing SOFs flag suspend bit 9
// RULE8: Resume while suspended sets wake bit 10
// RULE9: Reset during suspend sets bit 11
// RULE10: Test bit lets counters run, shows FSMs
// RULE11: Field 3:1 picks visible state machine
// RULE12: Field 5:4 picks counter, loads bits 14:8
// RULE13: Loaded counter plus one shown next cycle
// RULE14: Idle over 3 ms enters suspend
// RULE15: Host resume lasts 20 ms, ends EOP
// RULE16: Remote wake waits 5 ms, drives 11 ms
// RULE17: Bulk IN sends 64-byte packets from buffer
// RULE18: Two buffers alternate; end-of-transfer sends short
// RULE19: Single buffer wraps pointer to start
// RULE20: Isochronous transmit fetches continuously, self-incrementing; the code does not increment and restarts at the buffer start after each fetch
// RULE21: Bulk receive writes 64 bytes, interrupts at end
// RULE22: Isochronous receive drains continuously, interrupts at end
// RULE23: Suspend, wake, reset bits clear by one
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`include "usd_defines.vh"
module usd_status #(
  parameter IDLE_CYC  = `USD_US_CYCLES(`USD_IDLE_US),
  parameter WWAIT_CYC = `USD_US_CYCLES(`USD_WAKE_WAIT_US),
  parameter WDRV_CYC  = `USD_US_CYCLES(`USD_WAKE_DRIVE_US)
) (
  input  wire        SYS_CLK,
  input  wire        RSTN,
  input  wire        CLK_EN,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [15:0] WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire        SOF_TOKEN,
  input  wire        END_OF_TRANSACTION,
  input  wire [2:0]  LAST_ENDPOINT,
  input  wire [6:0]  RX_PKT_BYTES,
  input  wire        BUS_ACTIVITY,
  input  wire        BUS_RESET_SEEN,
  input  wire        HOST_RESUME,
  input  wire        REMOTE_WAKE_REQ,
  input  wire        IN_TOKEN,
  input  wire        RX_PKT_DONE,
  input  wire        ISO_MODE,
  input  wire        MEM_ACK,
  input  wire [7:0]  MAIN_SM_STATE,
  input  wire [7:0]  EP_SM_STATE0,
  input  wire [7:0]  EP_SM_STATE1,
  input  wire [7:0]  EP_SM_STATE2,
  input  wire [7:0]  EP_SM_STATE3,
  input  wire [7:0]  EP_SM_STATE4,
  output reg         SUSPENDED,
  output reg         RESUME_DRIVE,
  output reg         MEM_REQ,
  output reg         MEM_WRITE,
  output reg  [14:0] MEM_ADDR,
  output reg         SEND_SHORT_PKT
);
  localparam EP_CTRL_TX = 3'd0;
  localparam EP_CTRL_RX = 3'd1;
  localparam EP_INT     = 3'd2;
  localparam EP_BULK_TX = 3'd3;
  localparam EP_BULK_RX = 3'd4;
  localparam TX_IDLE    = 2'd0;
  localparam TX_FETCH   = 2'd1;
  localparam RX_IDLE    = 1'b0;
  localparam RX_WRITE   = 1'b1;

  // Byte-enable merge shared by every writable register
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) wmerge[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
  endfunction

  reg  [31:0] main_ctrl_r;
  reg  [`USD_STATUS_W-1:0] status_r;
  reg  [31:0] test_ctrl_r;
  reg  [6:0]  cnt1_r;
  reg  [6:0]  cnt2_r;
  reg  [6:0]  cnt3_r;
  reg  [31:0] tx_ctrl_r;
  reg  [31:0] tx_buf1_r;
  reg  [31:0] tx_buf2_r;
  reg  [31:0] rx_ctrl_r;
  reg  [31:0] rx_buf1_r;
  reg  [31:0] rx_buf2_r;
  reg  [31:0] rx_size1_r;
  reg  [31:0] rx_size2_r;
  reg         sof_d_r;
  reg         eot_d_r;
  reg  [2:0]  miss_frames_r;
  reg  [31:0] idle_cnt_r;
  reg  [31:0] wake_cnt_r;
  reg         wake_phase_r;
  reg  [1:0]  tx_state_r;
  reg         tx_sel_r;
  reg  [11:0] tx_ofs_r;
  reg         rx_state_r;
  reg         rx_sel_r;
  reg  [14:0] rx_ptr_r;
  reg  [11:0] rx_cnt_r;
  reg         tx_end_evt;
  reg         rx_end_evt;
  reg  [`USD_STATUS_W-1:0] set_evt;
  reg  [`USD_STATUS_W-1:0] clr_evt;
  reg  [7:0]  sm_view;
  reg  [6:0]  cnt_view;
  reg  [31:0] rd_data;

  wire wb_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wb_wr    = wb_req & WB_WE_I;
  wire test_on  = test_ctrl_r[`USD_TEST_EN];
  wire sof_rise = SOF_TOKEN & ~sof_d_r;
  wire eot_rise = END_OF_TRANSACTION & ~eot_d_r;
  wire test_wr  = wb_wr && WB_ADR_I == `USD_OFF_TEST_CTRL;
  wire [31:0] test_nxt = test_wr ? wmerge(test_ctrl_r, WB_DAT_I, WB_SEL_I) & `USD_TEST_CTRL_MASK
                                 : test_ctrl_r;
  wire [1:0] cnt_sel = test_nxt[`USD_TEST_CNT_HI:`USD_TEST_CNT_LO];
  wire [6:0] cnt_load = test_nxt[`USD_TEST_LOAD_HI:`USD_TEST_LOAD_LO];
  wire [31:0] clr_word = wmerge(32'h0, WB_DAT_I, WB_SEL_I);
  wire miss_tick = !BUS_ACTIVITY && miss_frames_r != `USD_FRAMES_SUSPEND &&
                   idle_cnt_r == (IDLE_CYC / 3) * (miss_frames_r + 3'h1);
  wire [31:0] tx_cur = tx_sel_r ? tx_buf2_r : tx_buf1_r;
  wire [11:0] tx_size = tx_cur[`USD_BUF_SIZE_HI:`USD_BUF_SIZE_LO];
  wire [31:0] rx_cur = rx_sel_r ? rx_buf2_r : rx_buf1_r;
  wire [14:0] rx_end = rx_cur[`USD_BUF_END_HI:`USD_BUF_END_LO];
  wire tx_owned = tx_sel_r ? tx_ctrl_r[`USD_DMA_OWN2] : tx_ctrl_r[`USD_DMA_OWN1];
  wire tx_two   = tx_ctrl_r[`USD_DMA_TWO_BUF];
  wire rx_two   = rx_ctrl_r[`USD_DMA_TWO_BUF];

  always @* begin
    case (test_ctrl_r[`USD_TEST_SM_HI:`USD_TEST_SM_LO]) // RULE11
      3'h1:    sm_view = MAIN_SM_STATE;
      3'h2:    sm_view = EP_SM_STATE0;
      3'h3:    sm_view = EP_SM_STATE1;
      3'h4:    sm_view = EP_SM_STATE2;
      3'h5:    sm_view = EP_SM_STATE3;
      3'h6:    sm_view = EP_SM_STATE4;
      default: sm_view = 8'h00;
    endcase
    case (cnt_sel)
      2'h1:    cnt_view = cnt1_r;
      2'h2:    cnt_view = cnt2_r;
      2'h3:    cnt_view = cnt3_r;
      default: cnt_view = 7'h00;
    endcase
  end

  always @* begin
    set_evt = {`USD_STATUS_W{1'b0}};
    set_evt[`USD_BIT_SOF] = sof_rise; // RULE1
    if (eot_rise) begin
      set_evt[`USD_BIT_CONTROL_ENDPOINT_TRANSMIT]  = LAST_ENDPOINT == EP_CTRL_TX; // RULE2
      set_evt[`USD_BIT_CONTROL_ENDPOINT_RECEIVE]  = LAST_ENDPOINT == EP_CTRL_RX; // RULE2
      set_evt[`USD_BIT_INT_EP]  = LAST_ENDPOINT == EP_INT; // RULE2
      set_evt[`USD_BIT_BULK_TX] = LAST_ENDPOINT == EP_BULK_TX; // RULE3
      set_evt[`USD_BIT_BULK_RX] = LAST_ENDPOINT == EP_BULK_RX; // RULE3
      set_evt[`USD_BIT_RX_XFER_END] = LAST_ENDPOINT == EP_BULK_RX &&
                                      RX_PKT_BYTES < `USD_PKT_BYTES; // RULE6
    end
    set_evt[`USD_BIT_TX_BUF_END] = tx_end_evt; // RULE4
    set_evt[`USD_BIT_RX_BUF_END] = rx_end_evt; // RULE5
    set_evt[`USD_BIT_SUSPEND] = miss_tick && miss_frames_r == `USD_FRAMES_SUSPEND - 3'd1; // RULE7
    // Resume detection only needs the level; with a stopped clock it is caught at restart
    set_evt[`USD_BIT_WAKEUP]    = SUSPENDED & HOST_RESUME; // RULE8
    set_evt[`USD_BIT_BUS_RESET] = SUSPENDED & BUS_RESET_SEEN; // RULE9
    set_evt = set_evt & {1'b1, main_ctrl_r[`USD_ENABLE_BASE +: `USD_STATUS_W - 1]}; // RULE7 RULE9
    clr_evt = {`USD_STATUS_W{1'b0}};
    if (wb_wr && WB_ADR_I == `USD_OFF_IRQ_STATUS)
      clr_evt = clr_word[`USD_STATUS_W-1:0]; // RULE23
  end

  always @* begin
    case (WB_ADR_I)
      `USD_OFF_MAIN_CTRL:   rd_data = main_ctrl_r;
      `USD_OFF_IRQ_STATUS:  rd_data = {20'h0, status_r};
      `USD_OFF_TEST_CTRL:   rd_data = test_ctrl_r;
      `USD_OFF_TEST_RESULT: rd_data = test_on ? {17'h0, cnt_view, sm_view} : 32'h0; // RULE10
      `USD_OFF_TX_DMA_CTRL: rd_data = tx_ctrl_r;
      `USD_OFF_TX_BUF1:     rd_data = tx_buf1_r;
      `USD_OFF_TX_BUF2:     rd_data = tx_buf2_r;
      `USD_OFF_RX_DMA_CTRL: rd_data = rx_ctrl_r;
      `USD_OFF_RX_BUF1:     rd_data = rx_buf1_r;
      `USD_OFF_RX_BUF2:     rd_data = rx_buf2_r;
      `USD_OFF_RX_SIZE1:    rd_data = rx_size1_r;
      `USD_OFF_RX_SIZE2:    rd_data = rx_size2_r;
      default:              rd_data = 32'h0;
    endcase
  end

  // Register file and bus slave; every access is acknowledged one running cycle after it starts
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      WB_ACK_O    <= 1'b0;
      WB_DAT_O    <= 32'h0;
      main_ctrl_r <= `USD_RESET_VALUE;
      status_r    <= {`USD_STATUS_W{1'b0}};
      test_ctrl_r <= `USD_RESET_VALUE;
      tx_buf1_r   <= `USD_RESET_VALUE;
      tx_buf2_r   <= `USD_RESET_VALUE;
      rx_buf1_r   <= `USD_RESET_VALUE;
      rx_buf2_r   <= `USD_RESET_VALUE;
      rx_size1_r  <= `USD_RESET_VALUE;
      rx_size2_r  <= `USD_RESET_VALUE;
      sof_d_r     <= 1'b0;
      eot_d_r     <= 1'b0;
    end else if (CLK_EN) begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= wb_req ? rd_data : 32'h0;
      sof_d_r  <= SOF_TOKEN;
      eot_d_r  <= END_OF_TRANSACTION;
      // Set wins over a simultaneous write-one clear
      status_r <= (status_r & ~clr_evt) | set_evt; // RULE1 RULE2 RULE3
      if (wb_wr) begin
        case (WB_ADR_I)
          `USD_OFF_MAIN_CTRL: main_ctrl_r <= wmerge(main_ctrl_r, WB_DAT_I, WB_SEL_I);
          `USD_OFF_TEST_CTRL: test_ctrl_r <= test_nxt;
          `USD_OFF_TX_BUF1:   tx_buf1_r <= wmerge(tx_buf1_r, WB_DAT_I, WB_SEL_I);
          `USD_OFF_TX_BUF2:   tx_buf2_r <= wmerge(tx_buf2_r, WB_DAT_I, WB_SEL_I);
          `USD_OFF_RX_BUF1:   rx_buf1_r <= wmerge(rx_buf1_r, WB_DAT_I, WB_SEL_I);
          `USD_OFF_RX_BUF2:   rx_buf2_r <= wmerge(rx_buf2_r, WB_DAT_I, WB_SEL_I);
          `USD_OFF_RX_SIZE1:  rx_size1_r <= wmerge(rx_size1_r, WB_DAT_I, WB_SEL_I);
          `USD_OFF_RX_SIZE2:  rx_size2_r <= wmerge(rx_size2_r, WB_DAT_I, WB_SEL_I);
          default: ;
        endcase
      end
      if (rx_end_evt) begin
        if (rx_sel_r) rx_size2_r <= {20'h0, rx_cnt_r};
        else rx_size1_r <= {20'h0, rx_cnt_r};
      end
    end
  end

  // Test counters: a load takes effect at the write edge, then they count up
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt1_r <= 7'h0;
      cnt2_r <= 7'h0;
      cnt3_r <= 7'h0;
    end else if (CLK_EN && test_nxt[`USD_TEST_EN]) begin // RULE10
      if (test_wr) begin
        if (cnt_sel == 2'h1) cnt1_r <= cnt_load; // RULE12
        if (cnt_sel == 2'h2) cnt2_r <= cnt_load; // RULE12
        if (cnt_sel == 2'h3) cnt3_r <= cnt_load; // RULE12
      end else begin
        cnt1_r <= cnt1_r + 7'h1; // RULE13
        cnt2_r <= cnt2_r + 7'h1; // RULE13
        cnt3_r <= cnt3_r + 7'h1; // RULE13
      end
    end
  end

  // Suspend detection, frame watch and remote wake timing
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      SUSPENDED     <= 1'b0;
      RESUME_DRIVE  <= 1'b0;
      miss_frames_r <= 3'h0;
      idle_cnt_r    <= 32'h0;
      wake_cnt_r    <= 32'h0;
      wake_phase_r  <= 1'b0;
    end else if (CLK_EN) begin
      // Idle count keeps running through suspend so later missed frames are still seen
      if (BUS_ACTIVITY) begin
        idle_cnt_r    <= 32'h0;
        miss_frames_r <= 3'h0;
        SUSPENDED     <= 1'b0; // RULE14
        if (!RESUME_DRIVE) wake_cnt_r <= 32'h0;
      end else begin
        idle_cnt_r <= idle_cnt_r + {31'h0, ~&idle_cnt_r};
        if (idle_cnt_r > IDLE_CYC) SUSPENDED <= 1'b1; // RULE14
        if (miss_tick) miss_frames_r <= miss_frames_r + 3'h1; // RULE7
      end
      // Host resume (RULE15) alone does not clear SUSPENDED; the device wakes on the BUS_ACTIVITY that ends it
      if (SUSPENDED && REMOTE_WAKE_REQ && !wake_phase_r) begin
        if (wake_cnt_r >= WWAIT_CYC) begin // RULE16
          wake_phase_r <= 1'b1;
          RESUME_DRIVE <= 1'b1;
          wake_cnt_r   <= 32'h0;
        end else begin
          wake_cnt_r <= wake_cnt_r + 32'h1;
        end
      end else if (wake_phase_r) begin
        if (wake_cnt_r >= WDRV_CYC - 1) begin // RULE16
          RESUME_DRIVE <= 1'b0;
          wake_phase_r <= 1'b0;
          wake_cnt_r   <= 32'h0;
        end else begin
          wake_cnt_r <= wake_cnt_r + 32'h1;
        end
      end else if (!SUSPENDED) begin
        wake_cnt_r <= 32'h0;
      end
    end
  end

  // Transmit and receive DMA walk through the buffers
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_ctrl_r      <= `USD_RESET_VALUE;
      rx_ctrl_r      <= `USD_RESET_VALUE;
      tx_state_r     <= TX_IDLE;
      tx_sel_r       <= 1'b0;
      tx_ofs_r       <= 12'h0;
      rx_state_r     <= RX_IDLE;
      rx_sel_r       <= 1'b0;
      rx_ptr_r       <= 15'h0;
      rx_cnt_r       <= 12'h0;
      tx_end_evt     <= 1'b0;
      rx_end_evt     <= 1'b0;
      MEM_REQ        <= 1'b0;
      MEM_WRITE      <= 1'b0;
      MEM_ADDR       <= 15'h0;
      SEND_SHORT_PKT <= 1'b0;
    end else if (CLK_EN) begin
      tx_end_evt     <= 1'b0;
      rx_end_evt     <= 1'b0;
      SEND_SHORT_PKT <= 1'b0;
      if (wb_wr && WB_ADR_I == `USD_OFF_TX_DMA_CTRL)
        tx_ctrl_r <= wmerge(tx_ctrl_r, WB_DAT_I, WB_SEL_I);
      if (wb_wr && WB_ADR_I == `USD_OFF_RX_DMA_CTRL)
        rx_ctrl_r <= wmerge(rx_ctrl_r, WB_DAT_I, WB_SEL_I);
      case (tx_state_r)
        TX_IDLE: begin
          if (tx_ctrl_r[`USD_DMA_ENABLE] && tx_owned && (IN_TOKEN || ISO_MODE)) begin // RULE17
            tx_state_r <= TX_FETCH;
            MEM_REQ    <= 1'b1;
            MEM_WRITE  <= 1'b0;
            MEM_ADDR   <= tx_cur[`USD_BUF_ADDR_HI:0] + {3'h0, tx_ofs_r};
          end
        end
        TX_FETCH: begin
          if (MEM_ACK) begin
            MEM_REQ    <= 1'b0;
            tx_state_r <= TX_IDLE;
            // Isochronous uses the whole buffer as one packet; bulk moves 64 bytes
            if (ISO_MODE || tx_ofs_r + `USD_PKT_BYTES > tx_size) begin // RULE20
              tx_ofs_r   <= 12'h0; // RULE19
              tx_end_evt <= 1'b1; // RULE4
              SEND_SHORT_PKT <= tx_sel_r ? tx_ctrl_r[`USD_DMA_EOT2] :
                                           tx_ctrl_r[`USD_DMA_EOT1]; // RULE18
              if (!ISO_MODE) begin
                if (tx_sel_r) tx_ctrl_r[`USD_DMA_OWN2] <= 1'b0;
                else tx_ctrl_r[`USD_DMA_OWN1] <= 1'b0;
              end
              if (tx_two) tx_sel_r <= ~tx_sel_r; // RULE18
            end else begin
              tx_ofs_r <= tx_ofs_r + `USD_PKT_BYTES;
            end
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
      case (rx_state_r)
        RX_IDLE: begin
          if (rx_ctrl_r[`USD_DMA_ENABLE] && RX_PKT_DONE && tx_state_r == TX_IDLE) begin
            rx_state_r <= RX_WRITE; // RULE21 RULE22
            MEM_REQ    <= 1'b1;
            MEM_WRITE  <= 1'b1;
            MEM_ADDR   <= rx_ptr_r == 15'h0 ? rx_cur[`USD_BUF_ADDR_HI:0] : rx_ptr_r;
            rx_cnt_r   <= rx_cnt_r + {5'h0, RX_PKT_BYTES};
          end
        end
        RX_WRITE: begin
          if (MEM_ACK) begin
            MEM_REQ    <= 1'b0;
            rx_state_r <= RX_IDLE;
            if (MEM_ADDR + 15'd64 > rx_end || rx_ctrl_r[`USD_DMA_ISO_END]) begin
              rx_end_evt <= 1'b1; // RULE5 RULE21 RULE22
              rx_ptr_r   <= 15'h0;
              rx_cnt_r   <= 12'h0;
              if (rx_sel_r) rx_ctrl_r[`USD_DMA_OWN2] <= 1'b1;
              else rx_ctrl_r[`USD_DMA_OWN1] <= 1'b1;
              if (rx_two) rx_sel_r <= ~rx_sel_r;
            end else begin
              rx_ptr_r <= MEM_ADDR + 15'd64;
            end
          end
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end
endmodule

// *** bench/usd_status_monitor.sv ***
// Port-level assertions for the USB device status block
`timescale 1ns/1ps
module usd_status_monitor #(
  parameter IDLE_CYC  = 40,
  parameter WWAIT_CYC = 20,
  parameter WDRV_CYC  = 30
) (
  input wire        SYS_CLK,
  input wire        RSTN,
  input wire        CLK_EN,
  input wire        WB_CYC_I,
  input wire        WB_STB_I,
  input wire        WB_ACK_O,
  input wire        BUS_ACTIVITY,
  input wire        MEM_ACK,
  input wire        MEM_REQ,
  input wire        MEM_WRITE,
  input wire [14:0] MEM_ADDR,
  input wire        SUSPENDED,
  input wire        RESUME_DRIVE
);
  logic [15:0] idle_cnt;
  logic [15:0] susp_cnt;
  logic [15:0] drv_cnt;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);
  // Counts saturate so a long idle spell never wraps into a false match
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      idle_cnt <= 16'h0;
      susp_cnt <= 16'h0;
      drv_cnt  <= 16'h0;
    end else begin
      idle_cnt <= BUS_ACTIVITY ? 16'h0 : idle_cnt + {15'h0, ~&idle_cnt};
      susp_cnt <= SUSPENDED ? susp_cnt + {15'h0, ~&susp_cnt} : 16'h0;
      drv_cnt  <= RESUME_DRIVE ? drv_cnt + {15'h0, ~&drv_cnt} : 16'h0;
    end
  end
  AST_ACK_NEXT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN |=> WB_ACK_O)
    else $error("ack missing one cycle after request");
  AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  AST_MEM_HOLD: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR)
    && $stable(MEM_WRITE)) else $error("memory request changed before ack");
  AST_MEM_DROP: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ)
    else $error("memory request held after ack");
  AST_SUSP_LATE: assert property ($rose(SUSPENDED) |-> idle_cnt >= IDLE_CYC)
    else $error("suspend entered too early");
  AST_SUSP_EXIT: assert property (SUSPENDED && BUS_ACTIVITY |-> ##[1:2] !SUSPENDED)
    else $error("suspend kept despite activity");
  AST_WAKE_WAIT: assert property ($rose(RESUME_DRIVE) |-> susp_cnt >= WWAIT_CYC)
    else $error("remote wake driven too soon");
  AST_WAKE_LEN: assert property ($fell(RESUME_DRIVE) |-> drv_cnt == WDRV_CYC)
    else $error("remote wake length wrong");
  cover property (WB_ACK_O);
  cover property ($rose(SUSPENDED));
  cover property (MEM_REQ && MEM_ACK && MEM_WRITE);
endmodule

// *** bench/usd_host_model.sv ***
// Host side of the USB serial bus as seen by the status block
`timescale 1ns/1ps
module usd_host_model #(
  parameter RES_CYC = 60
) (
  input  wire        clk,
  output logic       sof,
  output logic       end_of_transaction,
  output logic       act,
  output logic       brst,
  output logic       resume,
  output logic       in_tok,
  output logic       rx_done,
  output logic [2:0] ep,
  output logic [6:0] len
);
  initial begin
    {sof, end_of_transaction, brst, resume, in_tok, rx_done} = 6'h0;
    act = 1'b1;
    ep = 3'h0;
    len = 7'h0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic set_act(input logic a);
    act <= a;
    wait_n(1);
  endtask
  task automatic frame();
    sof <= 1'b1;
    wait_n(2);
    sof <= 1'b0;
    wait_n(2);
  endtask
  // Endpoint and size lines lose their value once the transaction is over
  task automatic pkt(input logic [2:0] e, input logic [6:0] n);
    ep <= e;
    len <= n;
    wait_n(1);
    end_of_transaction <= 1'b1;
    wait_n(2);
    end_of_transaction <= 1'b0;
    ep <= ~e;
    len <= ~n;
    wait_n(2);
  endtask
  // Full-length resume, closed by raising line activity, left high afterwards, as end of packet
  task automatic host_resume();
    resume <= 1'b1;
    wait_n(RES_CYC);
    resume <= 1'b0;
    act <= 1'b1;
    wait_n(3);
  endtask
  task automatic pulse(input int k);
    {brst, rx_done, in_tok} <= 3'(1 << k);
    wait_n(k == 2 ? 3 : 1);
    {brst, rx_done, in_tok} <= 3'h0;
    wait_n(1);
  endtask
endmodule

// *** bench/test_usd_status.sv ***
// Self-checking bench for the USB device status block
`timescale 1ns/1ps
`include "usd_defines.vh"
module test_usd_status;
  localparam [15:0] ST = `USD_OFF_IRQ_STATUS;
  localparam [15:0] TC = `USD_OFF_TEST_CTRL;
  localparam [15:0] TR = `USD_OFF_TEST_RESULT;
  localparam int    WDRV = 30;
  logic        SYS_CLK = 1'b0;
  logic        RSTN, CLK_EN, WB_CYC_I, WB_STB_I, WB_WE_I, REMOTE_WAKE_REQ, MEM_ACK, short_seen;
  logic [15:0] WB_ADR_I;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, v, exp_st;
  logic [7:0]  sm [6];
  wire         WB_ACK_O, SUSPENDED, RESUME_DRIVE, MEM_REQ, MEM_WRITE, SEND_SHORT_PKT;
  wire         SOF_TOKEN, END_OF_TRANSACTION, BUS_ACTIVITY, BUS_RESET_SEEN;
  wire         HOST_RESUME, IN_TOKEN, RX_PKT_DONE;
  wire [2:0]   LAST_ENDPOINT;
  wire [6:0]   RX_PKT_BYTES;
  wire [14:0]  MEM_ADDR;
  int          mismatches, n_tests, cyc_n, n;
  logic [31:0] seed = 32'h388f;
  always #5 SYS_CLK = ~SYS_CLK;
  usd_status #(.IDLE_CYC(40), .WWAIT_CYC(20), .WDRV_CYC(WDRV)) u_dut (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SOF_TOKEN(SOF_TOKEN),
    .END_OF_TRANSACTION(END_OF_TRANSACTION), .LAST_ENDPOINT(LAST_ENDPOINT),
    .RX_PKT_BYTES(RX_PKT_BYTES), .BUS_ACTIVITY(BUS_ACTIVITY), .BUS_RESET_SEEN(BUS_RESET_SEEN),
    .HOST_RESUME(HOST_RESUME), .REMOTE_WAKE_REQ(REMOTE_WAKE_REQ), .IN_TOKEN(IN_TOKEN),
    .RX_PKT_DONE(RX_PKT_DONE), .ISO_MODE(1'b0), .MEM_ACK(MEM_ACK), .MAIN_SM_STATE(sm[0]),
    .EP_SM_STATE0(sm[1]), .EP_SM_STATE1(sm[2]), .EP_SM_STATE2(sm[3]), .EP_SM_STATE3(sm[4]),
    .EP_SM_STATE4(sm[5]), .SUSPENDED(SUSPENDED), .RESUME_DRIVE(RESUME_DRIVE),
    .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR),
    .SEND_SHORT_PKT(SEND_SHORT_PKT));
  usd_host_model u_host (.clk(SYS_CLK), .sof(SOF_TOKEN), .end_of_transaction(END_OF_TRANSACTION),
    .act(BUS_ACTIVITY), .brst(BUS_RESET_SEEN), .resume(HOST_RESUME), .in_tok(IN_TOKEN),
    .rx_done(RX_PKT_DONE), .ep(LAST_ENDPOINT), .len(RX_PKT_BYTES));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  // Request held until ack is sampled; released only after that edge
  task wb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= w;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    @(posedge SYS_CLK);
    while (WB_ACK_O !== 1'b1) @(posedge SYS_CLK);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task rd(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task wait_req();
    while (MEM_REQ !== 1'b1) @(posedge SYS_CLK);
  endtask
  // Memory side answers every request one cycle later
  always @(posedge SYS_CLK) MEM_ACK <= MEM_REQ && !MEM_ACK;
  always @(posedge SYS_CLK) if (SEND_SHORT_PKT) short_seen <= 1'b1;
  always @(posedge SYS_CLK) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 10000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    {RSTN, WB_CYC_I, WB_STB_I, WB_WE_I, REMOTE_WAKE_REQ} = 5'h0;
    {WB_ADR_I, WB_SEL_I, WB_DAT_I} = '0;
    CLK_EN = 1'b1;
    WB_SEL_I = 4'hf;
    foreach (sm[i]) sm[i] = rnd();
    repeat (12) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    @(posedge SYS_CLK);
    for (int a = 'h1040; a <= 'h107c; a += 4) rd(16'(a), 32'h0);
    wr(TR, 32'hffff_ffff);
    wr(16'h1050, 32'hffff_ffff);
    rd(TR, 32'h0);
    rd(16'h1050, 32'h0);
    u_host.frame();
    rd(ST, 32'h0);
    wr(`USD_OFF_MAIN_CTRL, 32'h0fff_0000);
    u_host.frame();
    exp_st = 32'h1;
    for (int e = 0; e < 5; e++) u_host.pkt(3'(e), 7'd64);
    u_host.pkt(3'd4, 7'(rnd() % 64));
    exp_st = 32'h13f;
    rd(ST, exp_st);
    wr(ST, exp_st);
    rd(ST, 32'h0);
    for (int s = 1; s <= 6; s++) begin
      v = rnd() & 32'h7f;
      sm[s - 1] <= rnd();
      wr(TC, (v << 8) | (32'((s - 1) % 3 + 1) << 4) | (32'(s) << 1) | 32'h1);
      // Enable low must freeze the counters; the read lands two running cycles after the load
      CLK_EN <= 1'b0;
      repeat (s) @(posedge SYS_CLK);
      CLK_EN <= 1'b1;
      rd(TR, {17'h0, 7'(v + 2), sm[s - 1]});
    end
    wr(TC, 32'h0);
    rd(TR, 32'h0);
    wr(`USD_OFF_TX_BUF1, 32'h003f_0040);
    wr(`USD_OFF_TX_DMA_CTRL, 32'h0000_0501);
    u_host.pulse(0);
    wait_req();
    chk("tx addr", 32'h40, {17'h0, MEM_ADDR});
    chk("tx dir", 32'h0, {31'h0, MEM_WRITE});
    repeat (150) @(posedge SYS_CLK);
    rd(ST, 32'h40);
    rd(`USD_OFF_TX_DMA_CTRL, 32'h401);
    chk("short pkt", 32'h1, {31'h0, short_seen});
    wr(`USD_OFF_RX_BUF1, 32'h0240_0200);
    wr(`USD_OFF_RX_DMA_CTRL, 32'h1);
    u_host.pulse(1);
    wait_req();
    chk("rx addr", 32'h200, {17'h0, MEM_ADDR});
    chk("rx dir", 32'h1, {31'h0, MEM_WRITE});
    repeat (150) @(posedge SYS_CLK);
    wr(ST, 32'hfff);
    u_host.set_act(1'b0);
    repeat (100) @(posedge SYS_CLK);
    chk("suspended", 32'h1, {31'h0, SUSPENDED});
    u_host.pulse(2);
    u_host.host_resume();
    rd(ST, 32'he00);
    chk("suspended", 32'h0, {31'h0, SUSPENDED});
    wr(ST, 32'he00);
    rd(ST, 32'h0);
    u_host.set_act(1'b0);
    repeat (60) @(posedge SYS_CLK);
    REMOTE_WAKE_REQ <= 1'b1;
    while (RESUME_DRIVE !== 1'b1) @(posedge SYS_CLK);
    n = 0;
    while (RESUME_DRIVE === 1'b1 && n < 500) begin
      @(posedge SYS_CLK);
      n++;
    end
    chk("wake length", 32'(WDRV), 32'(n));
    REMOTE_WAKE_REQ <= 1'b0;
    u_host.host_resume();
    tally_and_finish();
  end
endmodule
bind usd_status usd_status_monitor #(.IDLE_CYC(IDLE_CYC), .WWAIT_CYC(WWAIT_CYC),
  .WDRV_CYC(WDRV_CYC)) u_mon (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CLK_EN(CLK_EN),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .BUS_ACTIVITY(BUS_ACTIVITY), .MEM_ACK(MEM_ACK), .MEM_REQ(MEM_REQ),
  .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR), .SUSPENDED(SUSPENDED),
  .RESUME_DRIVE(RESUME_DRIVE));
